//--- ppc_port.sv
// Purpose: one interrupt-capable port: pad control, readback, filtered pin interrupts
// Assumes: pad and peripheral inputs synchronous to i_core_clk; RC tick is a one-cycle strobe
// Notes: pad controls are combinational from registered settings, the peripheral inputs and i_stop
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "ppc_defs.svh"
module ppc_port
    import ppc_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Register port
    input wire ppc_bus_s i_bus,
    output logic [7:0] o_rdata,
    // Pads
    input wire ppc_bits_t i_pin_in,
    output ppc_bits_t o_pin_out,
    output ppc_bits_t o_pin_oe,
    output ppc_bits_t o_pull_en,
    output ppc_bits_t o_pull_up,
    output ppc_bits_t o_drive_reduced,
    output ppc_bits_t o_slew_en,
    // Peripheral taking over pins
    input wire ppc_bits_t i_per_en,
    input wire ppc_bits_t i_per_out,
    input wire ppc_bits_t i_per_oe,
    output ppc_bits_t o_reroute,
    // Power modes and RC filter clock
    input wire logic i_stop,
    input wire logic i_rc_tick,
    output logic o_rc_run,
    output logic o_irq,
    output logic o_wakeup,
    // Debug pin shared with mode select
    input wire logic i_debug_pin,
    output logic o_mode_select,
    output logic o_debug_pin_to_dbg
);
    ppc_state_s st;
    ppc_state_s next_st;
    logic samp;
    ppc_bits_t act;
    ppc_bits_t drv_oe;
    ppc_bits_t drv_val;

    // Filter strobe: every bus clock, or RC ticks while stopped
    assign samp = i_stop ? i_rc_tick : 1'b1;
    // Active level: polarity 1 is rising edge, 0 falling
    assign act = ~(i_pin_in ^ st.pol);

    // Per-pin pad control
    genvar g;
    generate
        for (g = 0; g < `PPC_NPIN; g++) begin : g_pad
            // Peripheral overrides direction and data
            assign drv_oe[g] = i_per_en[g] ? i_per_oe[g] : st.dir[g];
            assign drv_val[g] = i_per_en[g] ? i_per_out[g] : st.data[g];
            assign o_pin_out[g] = drv_val[g];
            // Wired-or output only pulls low
            assign o_pin_oe[g] = drv_oe[g] & ~(st.wom[g] & drv_val[g]);
            assign o_pull_en[g] = st.pullen[g] & (~drv_oe[g] | st.wom[g]);
            assign o_pull_up[g] = (drv_oe[g] & st.wom[g]) | ~st.pol[g];
            assign o_drive_reduced[g] = st.rdrv[g] & drv_oe[g];
            // Slew control forced off in stop to save current
            assign o_slew_en[g] = st.slew[g] & ~i_stop;
        end
    endgenerate

    // Shared request and wakeup
    assign o_irq = |(st.flag & st.ie);
    assign o_wakeup = o_irq;
    assign o_reroute = st.route;
    assign o_rdata = st.rdata;
    assign o_mode_select = st.mode_sel;
    // Debug function sees the pin only outside reset
    assign o_debug_pin_to_dbg = i_rst_b & i_debug_pin;

    // RC runs only for pins still able to fire
    always_comb begin
        o_rc_run = 1'b0;
        for (int i = 0; i < `PPC_NPIN; i++) begin
            if (i_stop && st.cnt[i] <= `PPC_FILT_N && st.ie[i] && !st.flag[i]) begin
                o_rc_run = 1'b1;
            end
        end
    end

    // Next state: register writes, reads, filters
    always_comb begin
        next_st = st;
        next_st.rdata = `PPC_RST_BYTE;
        if (i_bus.wr) begin
            if (i_bus.addr == `PPC_OFS_DATA) begin
                next_st.data = i_bus.wdata;
            end else if (i_bus.addr == `PPC_OFS_DIR) begin
                next_st.dir = i_bus.wdata;
            end else if (i_bus.addr == `PPC_OFS_RDRV) begin
                next_st.rdrv = i_bus.wdata;
            end else if (i_bus.addr == `PPC_OFS_PULLEN) begin
                next_st.pullen = i_bus.wdata;
            end else if (i_bus.addr == `PPC_OFS_POL) begin
                next_st.pol = i_bus.wdata;
            end else if (i_bus.addr == `PPC_OFS_WOM) begin
                next_st.wom = i_bus.wdata;
            end else if (i_bus.addr == `PPC_OFS_SLEW) begin
                next_st.slew = i_bus.wdata;
            end else if (i_bus.addr == `PPC_OFS_IE) begin
                next_st.ie = i_bus.wdata;
            end else if (i_bus.addr == `PPC_OFS_IF) begin
                next_st.flag = st.flag & ~i_bus.wdata;
            end else if (i_bus.addr == `PPC_OFS_ROUTE) begin
                next_st.route = i_bus.wdata;
            end
        end
        // Reads answer next cycle; unmapped reads give zero
        if (i_bus.rd) begin
            if (i_bus.addr == `PPC_OFS_DATA) begin
                next_st.rdata = (st.dir & st.data) | (~st.dir & i_pin_in);
            end else if (i_bus.addr == `PPC_OFS_INPUT) begin
                next_st.rdata = i_pin_in;
            end else if (i_bus.addr == `PPC_OFS_DIR) begin
                next_st.rdata = st.dir;
            end else if (i_bus.addr == `PPC_OFS_RDRV) begin
                next_st.rdata = st.rdrv;
            end else if (i_bus.addr == `PPC_OFS_PULLEN) begin
                next_st.rdata = st.pullen;
            end else if (i_bus.addr == `PPC_OFS_POL) begin
                next_st.rdata = st.pol;
            end else if (i_bus.addr == `PPC_OFS_WOM) begin
                next_st.rdata = st.wom;
            end else if (i_bus.addr == `PPC_OFS_SLEW) begin
                next_st.rdata = st.slew;
            end else if (i_bus.addr == `PPC_OFS_IE) begin
                next_st.rdata = st.ie;
            end else if (i_bus.addr == `PPC_OFS_IF) begin
                next_st.rdata = st.flag;
            end else if (i_bus.addr == `PPC_OFS_ROUTE) begin
                next_st.rdata = st.route;
            end
        end
        // Filter: run of equal samples, armed after 4 passive
        if (samp) begin
            for (int i = 0; i < `PPC_NPIN; i++) begin
                next_st.last[i] = act[i];
                if (act[i] != st.last[i]) begin
                    next_st.cnt[i] = `PPC_CNT_ONE;
                end else if (st.cnt[i] < `PPC_FILT_N) begin
                    next_st.cnt[i] = st.cnt[i] + `PPC_CNT_ONE;
                end
                if (!act[i] && next_st.cnt[i] == `PPC_FILT_N) begin
                    next_st.armed[i] = 1'b1;
                end
                // Uncertain passive glitches keep the arming
                if (act[i] && st.armed[i] && next_st.cnt[i] == `PPC_FILT_N) begin
                    next_st.armed[i] = 1'b0;
                    next_st.flag[i] = 1'b1;
                end
            end
        end
    end

    // Registered state; mode select follows the pin only during reset
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            st <= '0;
            st.mode_sel <= i_debug_pin;
        end else begin
            st <= next_st;
        end
    end

    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    sequence seq_four_act0;
        act[0] && samp ##1 act[0] && samp ##1 act[0] && samp ##1 act[0] && samp;
    endsequence

    chk_flag_clear: assert property (
        i_bus.wr && i_bus.addr == `PPC_OFS_IF && i_bus.wdata[0] && (!samp || !st.armed[0])
        |=> !st.flag[0]) else $error("flag not cleared by write one");
    chk_flag_hold: assert property (
        st.flag[0] && !(i_bus.wr && i_bus.addr == `PPC_OFS_IF && i_bus.wdata[0])
        |=> st.flag[0]) else $error("flag dropped without clear");
    chk_irq_gate: assert property (
        o_irq == |(st.flag & st.ie)) else $error("request not flag and enable");
    chk_edge_filter: assert property (
        !i_stop && $rose(st.flag[0]) |-> $past(act[0], 1) && $past(act[0], 4))
        else $error("flag rose after short pulse");
    chk_arm_fire: assert property (
        !i_stop && st.armed[0] && !st.flag[0] && !i_bus.wr ##0 seq_four_act0
        |=> st.flag[0]) else $error("valid edge missed");
    chk_wom_high: assert property (
        st.wom[0] && o_pin_out[0] |-> !o_pin_oe[0]) else $error("high side driven");
    chk_pull_off: assert property (
        o_pin_oe[0] && !st.wom[0] |-> !o_pull_en[0]) else $error("pull on push-pull");
    chk_pull_wom_up: assert property (
        o_pull_en[0] && st.wom[0] && o_pin_oe[0] |-> o_pull_up[0])
        else $error("pull-down on wired-or");
    chk_read_data: assert property (
        i_bus.rd && i_bus.addr == `PPC_OFS_DATA
        |=> o_rdata[0] == ($past(st.dir[0]) ? $past(st.data[0]) : $past(i_pin_in[0])))
        else $error("data readback source wrong");
    chk_rc_gate: assert property (
        o_rc_run |-> i_stop && |(st.ie & ~st.flag)) else $error("RC run without need");

    // The RC oscillator costs current, so it must never run outside stop
    chk_rc_stop_only: assert property (
        !i_stop |-> !o_rc_run) else $error("RC run outside stop");

    // Drive strength only matters while the pad actually drives
    chk_drive_sel: assert property (
        !st.wom[0] |-> o_drive_reduced[0] == (st.rdrv[0] && o_pin_oe[0]))
        else $error("drive strength select wrong");

    // Input pins take the pull type from the polarity bit
    chk_pull_input: assert property (
        o_pull_en[0] && !o_pin_oe[0] && !st.wom[0] |-> o_pull_up[0] == !st.pol[0])
        else $error("pull type on input wrong");

    // Slew control is forced off in stop and follows the register otherwise
    chk_slew_stop: assert property (
        i_stop |-> o_slew_en == '0) else $error("slew control on in stop");
    chk_slew_run: assert property (
        !i_stop |-> o_slew_en == st.slew) else $error("slew control not as set");

    // Routing output mirrors its register
    chk_route_out: assert property (
        o_reroute == st.route) else $error("routing output wrong");

    // Wakeup follows the shared request
    chk_wake_irq: assert property (
        o_wakeup == o_irq) else $error("wakeup differs from request");

    // Mode select is frozen once reset has gone away
    chk_mode_hold: assert property (
        i_rst_b |=> $stable(o_mode_select)) else $error("mode select moved after reset");

    // Debug logic sees the pin once reset is released
    chk_debug_pass: assert property (
        o_debug_pin_to_dbg == i_debug_pin) else $error("debug pin not passed");
endmodule

//--- ppc_defs.svh
// Purpose: register offsets, reset values and filter counts of the pin-port block
// Assumes: byte-wide registers on a plain strobe port
// Notes: the state and bus types live in ppc_pkg
// Contract
// - Reduced-drive bit sets output drive strength, for GPIO or peripheral output.
// - Pull device connects only for inputs or wired-or outputs.
// - Polarity picks pull-up or pull-down; wired-or outputs allow pull-up only.
// - Wired-or bit disables high-side drive; only low levels driven.
// - Per-pin enable masks the pin interrupt flag.
// - Filtered valid pin event sets the flag, which then holds.
// - Per-pin slew bit turns slew-rate control on or off; here forced off in stop whatever the bit.
// - Routing register moves PWM channel outputs to alternative ports.
// - During reset the debug pin serves as mode-select input.
// - Interrupt ports have per-pin enable and edge select.
// - All pins of a port share one interrupt request.
// - Edge detection works whether pin is input or output.
// - Request asserts whenever any flag and its enable are set.
// - Enabled pin interrupt wakes the core from stop and wait.
// - Pulses up to 3 samples ignored, 4 or more accepted.
// - Valid edge: 4 passive samples then 4 active samples.
// - Filters sample on bus clock, in stop on the RC oscillator.
// - In stop, RC runs only while a pin counts <=4, enabled, flag clear.
// - Data read returns pin level if direction 0, latch if 1.
// - Polarity bit also selects the active interrupt edge.
`ifndef PPC_DEFS_SVH
`define PPC_DEFS_SVH
`define PPC_NPIN 8
`define PPC_AW 4
`define PPC_OFS_DATA 4'h0
`define PPC_OFS_INPUT 4'h1
`define PPC_OFS_DIR 4'h2
`define PPC_OFS_RDRV 4'h3
`define PPC_OFS_PULLEN 4'h4
`define PPC_OFS_POL 4'h5
`define PPC_OFS_WOM 4'h6
`define PPC_OFS_SLEW 4'h7
`define PPC_OFS_IE 4'h8
`define PPC_OFS_IF 4'h9
`define PPC_OFS_ROUTE 4'hA
`define PPC_RST_BYTE 8'h00
`define PPC_CNT_W 3
`define PPC_CNT_ZERO 3'h0
`define PPC_CNT_ONE 3'h1
`define PPC_FILT_N 3'h4
`endif

//--- ppc_pkg.sv
// Purpose: types shared by the pin-port block
// Assumes: ppc_defs.svh supplies the widths
// Notes: one packed struct holds every flip-flop of the block
`include "ppc_defs.svh"
package ppc_pkg;
    typedef logic [`PPC_NPIN-1:0] ppc_bits_t;
    typedef logic [`PPC_AW-1:0] ppc_addr_t;
    typedef logic [`PPC_CNT_W-1:0] ppc_cnt_t;
    // Register bus request
    typedef struct packed {
        ppc_addr_t addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ppc_bus_s;
    // Whole block state
    typedef struct packed {
        ppc_bits_t data;
        ppc_bits_t dir;
        ppc_bits_t rdrv;
        ppc_bits_t pullen;
        ppc_bits_t pol;
        ppc_bits_t wom;
        ppc_bits_t slew;
        ppc_bits_t ie;
        ppc_bits_t flag;
        ppc_bits_t route;
        ppc_bits_t armed;
        ppc_bits_t last;
        ppc_cnt_t [`PPC_NPIN-1:0] cnt;
        logic [7:0] rdata;
        logic mode_sel;
    } ppc_state_s;
endpackage

//--- ppc_pad_model.sv
// Purpose: pad and board model that resolves each pin level of the port
// Assumes: the bench chooses which pins an outside source drives
// Notes: a floating pin shows the inverse of the block's current output value, never a settled copy
`timescale 1ns/1ps
module ppc_pad_model
    import ppc_pkg::*;
(
    // Block side of the pads
    input wire ppc_bits_t i_out,
    input wire ppc_bits_t i_oe,
    input wire ppc_bits_t i_pull_en,
    input wire ppc_bits_t i_pull_up,
    // Outside source
    input wire ppc_bits_t i_ext_drv,
    input wire ppc_bits_t i_ext_val,
    // Resolved level
    output ppc_bits_t o_level
);
    // Block drive wins, then the outside source, then the pull device
    always_comb begin
        for (int i = 0; i < `PPC_NPIN; i++) begin
            if (i_oe[i]) o_level[i] = i_out[i];
            else if (i_ext_drv[i]) o_level[i] = i_ext_val[i];
            else if (i_pull_en[i]) o_level[i] = i_pull_up[i];
            else o_level[i] = ~i_out[i];
        end
    end
endmodule

//--- port_pin_config_and_pin_interrupts_test.sv
// Purpose: self-checking bench for the pin-port block
// Assumes: one-cycle strobes with an idle cycle after each access
// Notes: pins 4 and 5 belong to a peripheral for the whole run
`timescale 1ns/1ps
`include "ppc_defs.svh"
module port_pin_config_and_pin_interrupts_test
    import ppc_pkg::*;
;
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    ppc_bus_s bus = '0;
    logic [7:0] rdata;
    ppc_bits_t pin, pin_out, pin_oe, pull_en, pull_up, drv_red, slew, reroute;
    ppc_bits_t per_en = 8'h30, per_out = 8'h10, per_oe = 8'h30, ext_drv = 8'hF0, ext_val = 8'h90;
    logic stop = 1'b0, rc_tick = 1'b0, rc_run, irq, wake, dbg_pin = 1'b1, mode_sel, dbg_out;
    int compares = 0, failures = 0;
    always #5 core_clk = ~core_clk;
    ppc_port dut (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_bus(bus), .o_rdata(rdata),
        .i_pin_in(pin), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pull_en(pull_en),
        .o_pull_up(pull_up), .o_drive_reduced(drv_red), .o_slew_en(slew), .i_per_en(per_en),
        .i_per_out(per_out), .i_per_oe(per_oe), .o_reroute(reroute), .i_stop(stop),
        .i_rc_tick(rc_tick), .o_rc_run(rc_run), .o_irq(irq), .o_wakeup(wake),
        .i_debug_pin(dbg_pin), .o_mode_select(mode_sel), .o_debug_pin_to_dbg(dbg_out));
    ppc_pad_model pads (.i_out(pin_out), .i_oe(pin_oe), .i_pull_en(pull_en),
        .i_pull_up(pull_up), .i_ext_drv(ext_drv), .i_ext_val(ext_val), .o_level(pin));
    // Bus cycles: strobe for one cycle, then idle
    task automatic wr(input ppc_addr_t a, input logic [7:0] d);
        @(posedge core_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk) bus <= '0;
        #1;
    endtask
    task automatic rd(input ppc_addr_t a, input logic [7:0] e);
        @(posedge core_clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk) bus <= '0;
        #1 `CHK("rdata", e, rdata)
    endtask
    // Outside pin levels held for a number of core clock cycles
    task automatic lvl(input ppc_bits_t v, input int len);
        @(posedge core_clk) ext_val <= v;
        repeat (len - 1) @(posedge core_clk);
    endtask
    task automatic conclude();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog well past the roughly 130 cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        dbg_pin <= 1'b0;
        for (int a = 2; a < 16; a++) rd(ppc_addr_t'(a), `PPC_RST_BYTE);
        `CHK("mode", 1'b1, mode_sel)
        `CHK("dbgpin", 1'b0, dbg_out)
        wr(`PPC_OFS_DATA, 8'h3C);
        wr(`PPC_OFS_DIR, 8'h0F);
        wr(`PPC_OFS_WOM, 8'h05);
        wr(`PPC_OFS_PULLEN, 8'hFF);
        wr(`PPC_OFS_POL, 8'h7F);
        wr(`PPC_OFS_RDRV, 8'hFF);
        wr(`PPC_OFS_SLEW, 8'hFF);
        wr(`PPC_OFS_ROUTE, 8'h5A);
        wr(`PPC_OFS_INPUT, 8'hFF);
        repeat (3) @(posedge core_clk);
        #1 `CHK("oe", 8'h3B, pin_oe)
        `CHK("per", 2'b01, pin_out[5:4])
        `CHK("drive", 8'h3B, drv_red & 8'h3B)
        `CHK("pull", 8'hC5, pull_en & 8'hCF)
        `CHK("pullup", 8'h85, pull_up & 8'hC5)
        `CHK("slew", 8'hFF, slew)
        `CHK("route", 8'h5A, reroute)
        rd(`PPC_OFS_DATA, 8'h9C);
        rd(`PPC_OFS_INPUT, 8'h9C);
        wr(`PPC_OFS_IF, 8'hFF);
        wr(`PPC_OFS_IE, 8'h40);
        lvl(8'hD0, 3);
        lvl(8'h90, 6);
        #1 `CHK("short", 1'b0, irq)
        lvl(8'hD0, 4);
        @(posedge core_clk);
        #1 `CHK("irq", 1'b1, irq)
        `CHK("wake", 1'b1, wake)
        rd(`PPC_OFS_IF, 8'h40);
        wr(`PPC_OFS_IF, 8'h00);
        rd(`PPC_OFS_IF, 8'h40);
        wr(`PPC_OFS_IF, 8'h40);
        `CHK("clr", 1'b0, irq)
        lvl(8'h50, 4);
        @(posedge core_clk);
        #1 `CHK("mask", 1'b0, irq)
        rd(`PPC_OFS_IF, 8'h80);
        wr(`PPC_OFS_DATA, 8'h3D);
        repeat (5) @(posedge core_clk);
        rd(`PPC_OFS_IF, 8'h81);
        lvl(8'h10, 5);
        wr(`PPC_OFS_IF, 8'hFF);
        stop <= 1'b1;
        #1 `CHK("rcrun", 1'b1, rc_run)
        lvl(8'h50, 10);
        rd(`PPC_OFS_IF, 8'h00);
        repeat (4) begin
            @(posedge core_clk) rc_tick <= 1'b1;
            @(posedge core_clk) rc_tick <= 1'b0;
        end
        @(posedge core_clk);
        #1 `CHK("stopirq", 1'b1, irq)
        `CHK("rcstop", 1'b0, rc_run)
        stop <= 1'b0;
        conclude();
    end
endmodule
